// ---- hw/i2cirq_pkg.sv ----
package i2cirq_pkg;
  // register byte offsets on the internal register bus
  localparam logic [19:0] INT_STATUS_OFFS = 20'h1_d11c;
  localparam logic [19:0] INT_ENABLE_OFFS = 20'h1_d120;
  localparam logic [19:0] INT_SET_OFFS = 20'h1_d124;
  localparam logic [31:0] INT_ENABLE_RST = 32'h0000_0000;
  localparam logic [31:0] INT_STATUS_RST = 32'h0000_0000;
  // status bit positions; register bit n of the table is bit n of the word
  localparam int OUTBOX_DRAINED_BIT = 6;
  localparam int INBOX_LOADED_BIT = 7;
  localparam int BOOTLOAD_FAILED_BIT = 14;
  localparam int BOOTLOAD_DONE_BIT = 15;
  localparam int TARGET_ACCESS_FAILED_BIT = 20;
  localparam int TARGET_REG_WRITE_DONE_BIT = 21;
  localparam int TARGET_REG_READ_DONE_BIT = 22;
  localparam int TARGET_ACCESS_DONE_BIT = 23;
  localparam int INITIATOR_DIAG_EVENT_BIT = 24;
  localparam int INITIATOR_ARB_LOST_BIT = 27;
  localparam int INITIATOR_TIMED_OUT_BIT = 28;
  localparam int INITIATOR_NACKED_BIT = 29;
  localparam int INITIATOR_ARB_TIMEOUT_BIT = 30;
  localparam int INITIATOR_DONE_BIT = 31;
  // implemented bits; the rest are reserved and read zero
  localparam logic [31:0] IMPL_MASK = 32'hf9f0_c0c0;
  typedef enum logic [1:0] {
    I2CIRQ_SRC_NONE,
    I2CIRQ_SRC_STATUS,
    I2CIRQ_SRC_ENABLE,
    I2CIRQ_SRC_SET
  } i2cirq_src_e;
endpackage : i2cirq_pkg

// ---- hw/i2cirq_flag_bank.sv ----
`timescale 1ns/1ps
module i2cirq_flag_bank #(
  parameter int WIDTH = 32,
  parameter logic [WIDTH-1:0] IMPL = '1
) (
  // clock, enable and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // set and clear strobes
  input wire logic [WIDTH-1:0] set_in,
  input wire logic [WIDTH-1:0] clear_in,
  // flags
  output logic [WIDTH-1:0] flags_out
);
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;
  // set wins over clear so a coincident event is kept
  assign flags_d = ((flags_q & ~clear_in) | set_in) & IMPL;
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flags_q <= '0;
    end else if (clk_en_in) begin
      flags_q <= flags_d;
    end
  end
  assign flags_out = flags_q;
  sticky_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && ((set_in & IMPL) != '0) |=> ((flags_q & $past(set_in) & IMPL) == ($past(set_in) & IMPL)))
    else $error("flag set was lost");
endmodule : i2cirq_flag_bank

// ---- hw/i2cirq_status_logic.sv ----
`timescale 1ns/1ps
module i2cirq_status_logic (
  // clock, enable and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // internal register bus
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [19:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  output logic reg_ack_out,
  // events from the engines, one-cycle pulses
  input wire logic outbox_drained_in,
  input wire logic inbox_loaded_in,
  input wire logic bootload_failed_in,
  input wire logic bootload_done_in,
  input wire logic target_access_failed_in,
  input wire logic target_reg_write_done_in,
  input wire logic target_reg_read_done_in,
  input wire logic target_access_done_in,
  input wire logic initiator_diag_event_in,
  input wire logic initiator_arb_lost_in,
  input wire logic initiator_timed_out_in,
  input wire logic initiator_nacked_in,
  input wire logic initiator_arb_timeout_in,
  input wire logic initiator_done_in,
  // forced events toward the new-event register
  output logic [31:0] force_event_out,
  // interrupt request to the interrupt controller
  output logic irq_out
);
  logic [31:0] enable_q;
  logic [31:0] enable_d;
  logic [31:0] status;
  logic [31:0] hw_events;
  logic [31:0] set_bits;
  logic [31:0] clr_bits;
  logic [31:0] force_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic irq_q;
  wire logic hit_status;
  wire logic hit_enable;
  wire logic hit_set;
  wire logic wr_stb;
  wire logic rd_stb;
  wire logic set_wr;
  wire logic clr_wr;
  wire logic en_wr;
  i2cirq_pkg::i2cirq_src_e src;

  // one comparator for all three registers keeps the decode identical
  function automatic logic addr_hit(input logic sel, input logic [19:0] addr, input logic [19:0] offs);
    addr_hit = sel && (addr == offs);
  endfunction : addr_hit

  assign hit_status = addr_hit(reg_sel_in, reg_addr_in, i2cirq_pkg::INT_STATUS_OFFS);
  assign hit_enable = addr_hit(reg_sel_in, reg_addr_in, i2cirq_pkg::INT_ENABLE_OFFS);
  assign hit_set = addr_hit(reg_sel_in, reg_addr_in, i2cirq_pkg::INT_SET_OFFS);
  assign wr_stb = reg_sel_in && reg_wr_in && clk_en_in;
  assign rd_stb = reg_sel_in && !reg_wr_in && clk_en_in;
  assign set_wr = wr_stb && hit_set;
  assign clr_wr = wr_stb && hit_status;
  assign en_wr = wr_stb && hit_enable;

  always_comb begin
    if (hit_status) begin
      src = i2cirq_pkg::I2CIRQ_SRC_STATUS;
    end else if (hit_enable) begin
      src = i2cirq_pkg::I2CIRQ_SRC_ENABLE;
    end else if (hit_set) begin
      src = i2cirq_pkg::I2CIRQ_SRC_SET;
    end else begin
      src = i2cirq_pkg::I2CIRQ_SRC_NONE;
    end
  end

  // boot failure reaches the master error bits only via the engines' own pulses
  always_comb begin
    hw_events = '0;
    hw_events[i2cirq_pkg::OUTBOX_DRAINED_BIT] = outbox_drained_in;
    hw_events[i2cirq_pkg::INBOX_LOADED_BIT] = inbox_loaded_in;
    hw_events[i2cirq_pkg::BOOTLOAD_FAILED_BIT] = bootload_failed_in;
    hw_events[i2cirq_pkg::BOOTLOAD_DONE_BIT] = bootload_done_in;
    hw_events[i2cirq_pkg::TARGET_ACCESS_FAILED_BIT] = target_access_failed_in;
    hw_events[i2cirq_pkg::TARGET_REG_WRITE_DONE_BIT] = target_reg_write_done_in;
    hw_events[i2cirq_pkg::TARGET_REG_READ_DONE_BIT] = target_reg_read_done_in;
    hw_events[i2cirq_pkg::TARGET_ACCESS_DONE_BIT] = target_access_done_in;
    hw_events[i2cirq_pkg::INITIATOR_DIAG_EVENT_BIT] = initiator_diag_event_in;
    hw_events[i2cirq_pkg::INITIATOR_ARB_LOST_BIT] = initiator_arb_lost_in;
    hw_events[i2cirq_pkg::INITIATOR_TIMED_OUT_BIT] = initiator_timed_out_in;
    hw_events[i2cirq_pkg::INITIATOR_NACKED_BIT] = initiator_nacked_in;
    hw_events[i2cirq_pkg::INITIATOR_ARB_TIMEOUT_BIT] = initiator_arb_timeout_in;
    hw_events[i2cirq_pkg::INITIATOR_DONE_BIT] = initiator_done_in;
  end

  // only this bus reaches enable and set; the serial slave path has no port here
  assign set_bits = hw_events | (set_wr ? reg_wdata_in : 32'h0000_0000);
  assign clr_bits = clr_wr ? reg_wdata_in : 32'h0000_0000;
  assign enable_d = en_wr ? (reg_wdata_in & i2cirq_pkg::IMPL_MASK) : enable_q;

  i2cirq_flag_bank #(
    .WIDTH(32),
    .IMPL(i2cirq_pkg::IMPL_MASK)
  ) u_flags (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .set_in(set_bits),
    .clear_in(clr_bits),
    .flags_out(status)
  );

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      enable_q <= i2cirq_pkg::INT_ENABLE_RST;
    end else if (clk_en_in) begin
      enable_q <= enable_d;
    end
  end

  // forced set is also handed to the new-event register as a one-cycle pulse
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      force_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      force_q <= set_wr ? (reg_wdata_in & i2cirq_pkg::IMPL_MASK) : 32'h0000_0000;
    end
  end

  // read data registered; set register reads zero, unmapped reads zero
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else if (clk_en_in) begin
      ack_q <= reg_sel_in;
      if (rd_stb) begin
        case (src)
          i2cirq_pkg::I2CIRQ_SRC_STATUS: rdata_q <= status;
          i2cirq_pkg::I2CIRQ_SRC_ENABLE: rdata_q <= enable_q;
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // registered so the request line never glitches during a bus write
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else if (clk_en_in) begin
      irq_q <= |(status & enable_q);
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_ack_out = ack_q;
  assign force_event_out = force_q;
  assign irq_out = irq_q;

  // checks sit next to the logic above; each names its own clock and reset
  irq_level_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in |=> irq_out == |($past(status) & $past(enable_q)))
    else $error("irq does not follow status and enable");

  enable_reset_a : assert property (@(posedge ref_clk_in)
    !rst_n_in |=> enable_q == 32'h0000_0000)
    else $error("enable not cleared by reset");

  enable_write_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    en_wr |=> enable_q == ($past(reg_wdata_in) & i2cirq_pkg::IMPL_MASK))
    else $error("enable write not stored");

  enable_hold_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && !en_wr |=> $stable(enable_q))
    else $error("enable changed without a write");

  w1c_clear_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clr_wr && reg_wdata_in[i2cirq_pkg::INITIATOR_DONE_BIT] && !initiator_done_in
    |=> !status[i2cirq_pkg::INITIATOR_DONE_BIT])
    else $error("write one did not clear");

  w1c_keep_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clr_wr && !reg_wdata_in[i2cirq_pkg::INITIATOR_NACKED_BIT]
    && status[i2cirq_pkg::INITIATOR_NACKED_BIT] |=> status[i2cirq_pkg::INITIATOR_NACKED_BIT])
    else $error("write zero changed status");

  status_sticky_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && !clr_wr |=> (status & $past(status)) == $past(status))
    else $error("status dropped without a clear");

  status_source_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && (hw_events == 32'h0000_0000) && !set_wr |=> (status & ~$past(status)) == 32'h0000_0000)
    else $error("status set without a source");

  force_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    set_wr |=> (status & $past(reg_wdata_in) & i2cirq_pkg::IMPL_MASK)
    == ($past(reg_wdata_in) & i2cirq_pkg::IMPL_MASK))
    else $error("forced set not applied");

  force_pulse_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    set_wr |=> force_event_out == ($past(reg_wdata_in) & i2cirq_pkg::IMPL_MASK))
    else $error("forced set not forwarded");

  force_idle_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && !set_wr |=> force_event_out == 32'h0000_0000)
    else $error("force pulse without a set write");

  arb_lost_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && initiator_arb_lost_in |=> status[i2cirq_pkg::INITIATOR_ARB_LOST_BIT])
    else $error("collision bit not set");

  timed_out_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && initiator_timed_out_in |=> status[i2cirq_pkg::INITIATOR_TIMED_OUT_BIT])
    else $error("timeout bit not set");

  nacked_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && initiator_nacked_in |=> status[i2cirq_pkg::INITIATOR_NACKED_BIT])
    else $error("nack bit not set");

  arb_timeout_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && initiator_arb_timeout_in |=> status[i2cirq_pkg::INITIATOR_ARB_TIMEOUT_BIT])
    else $error("arb timeout bit not set");

  done_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && initiator_done_in && clr_wr |=> status[i2cirq_pkg::INITIATOR_DONE_BIT])
    else $error("success lost against clear");

  mailbox_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && (inbox_loaded_in || outbox_drained_in) |=> (status[i2cirq_pkg::INBOX_LOADED_BIT]
    || status[i2cirq_pkg::OUTBOX_DRAINED_BIT]))
    else $error("mailbox bit not set");

  inbox_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && inbox_loaded_in |=> status[i2cirq_pkg::INBOX_LOADED_BIT])
    else $error("inbox bit not set");

  outbox_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && outbox_drained_in |=> status[i2cirq_pkg::OUTBOX_DRAINED_BIT])
    else $error("outbox bit not set");

  boot_done_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && bootload_done_in |=> status[i2cirq_pkg::BOOTLOAD_DONE_BIT])
    else $error("boot done bit not set");

  boot_fail_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && bootload_failed_in |=> status[i2cirq_pkg::BOOTLOAD_FAILED_BIT])
    else $error("boot failed bit not set");

  target_done_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && target_access_done_in |=> status[i2cirq_pkg::TARGET_ACCESS_DONE_BIT])
    else $error("slave done bit not set");

  event_set_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in && (hw_events != 32'h0000_0000) |=> (status & $past(hw_events)) == $past(hw_events))
    else $error("event pulse lost");

  ack_follow_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    clk_en_in |=> reg_ack_out == $past(reg_sel_in))
    else $error("ack does not follow select");

  read_status_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_stb && hit_status |=> reg_rdata_out == $past(status))
    else $error("status read wrong");

  read_enable_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_stb && hit_enable |=> reg_rdata_out == $past(enable_q))
    else $error("enable read wrong");

  read_zero_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_stb && !hit_status && !hit_enable |=> reg_rdata_out == 32'h0000_0000)
    else $error("set or unmapped read not zero");

  freeze_hold_a : assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !clk_en_in |=> $stable(status) && $stable(enable_q) && $stable(reg_ack_out) && $stable(irq_out)
    && $stable(force_event_out) && $stable(reg_rdata_out))
    else $error("state moved while clock enable low");

  reset_out_a : assert property (@(posedge ref_clk_in)
    !rst_n_in |=> (status == 32'h0000_0000) && !irq_out && !reg_ack_out
    && (force_event_out == 32'h0000_0000) && (reg_rdata_out == 32'h0000_0000))
    else $error("outputs not cleared by reset");
endmodule : i2cirq_status_logic

// ---- verification/i2cirq_intc_model.sv ----
`timescale 1ns/1ps
module i2cirq_intc_model (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // request from the block
  input wire logic irq_in,
  // requests seen
  output logic [15:0] irq_rise_cnt_out
);
  logic irq_q;
  // the line is a level; counting rises shows that it dropped between events
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
      irq_rise_cnt_out <= 16'h0000;
    end else begin
      irq_q <= irq_in;
      if (irq_in && !irq_q) begin
        irq_rise_cnt_out <= irq_rise_cnt_out + 16'h0001;
      end
    end
  end
endmodule : i2cirq_intc_model

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic reg_sel, reg_wr, reg_ack, irq, clk_en, irq_m;
  logic [19:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, force_ev, rd;
  logic [13:0] ev;
  logic [15:0] irq_rises;
  int num_errors = 0;
  int samples_checked = 0;
  int rises_m = 0;
  int cycles = 0;
  int seed = 32'h8f84;
  int st_m, en_m, k;
  int pos[14] = '{6, 7, 14, 15, 20, 21, 22, 23, 24, 27, 28, 29, 30, 31};
  logic [19:0] addrs[4] = '{i2cirq_pkg::INT_STATUS_OFFS, i2cirq_pkg::INT_ENABLE_OFFS,
    i2cirq_pkg::INT_SET_OFFS, 20'h1_d128};

  i2cirq_status_logic u_i2cirq_status_logic (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .clk_en_in(clk_en), .reg_sel_in(reg_sel), .reg_wr_in(reg_wr), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .reg_ack_out(reg_ack),
    .outbox_drained_in(ev[0]), .inbox_loaded_in(ev[1]), .bootload_failed_in(ev[2]),
    .bootload_done_in(ev[3]), .target_access_failed_in(ev[4]), .target_reg_write_done_in(ev[5]),
    .target_reg_read_done_in(ev[6]), .target_access_done_in(ev[7]), .initiator_diag_event_in(ev[8]),
    .initiator_arb_lost_in(ev[9]), .initiator_timed_out_in(ev[10]), .initiator_nacked_in(ev[11]),
    .initiator_arb_timeout_in(ev[12]), .initiator_done_in(ev[13]), .force_event_out(force_ev),
    .irq_out(irq));
  i2cirq_intc_model u_i2cirq_intc_model (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .irq_in(irq), .irq_rise_cnt_out(irq_rises));

  always #5 ref_clk_in = ~ref_clk_in;
  // a hung handshake ends the run here
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one register access with event pulses in the same cycle; the model follows
  task automatic acc(input logic wr, input logic [19:0] a, input logic [31:0] d, input logic [13:0] e);
    int n, evb, exp;
    evb = 0;
    for (n = 0; n < 14; n++) if (e[n]) evb |= 1 << pos[n];
    exp = (a == i2cirq_pkg::INT_STATUS_OFFS) ? st_m : (a == i2cirq_pkg::INT_ENABLE_OFFS) ? en_m : 0;
    @(negedge ref_clk_in);
    reg_sel = 1'b1;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    ev = e;
    @(negedge ref_clk_in);
    reg_sel = 1'b0;
    ev = '0;
    if (wr && a == i2cirq_pkg::INT_STATUS_OFFS) st_m &= ~d;
    if (wr && a == i2cirq_pkg::INT_ENABLE_OFFS) en_m = d & i2cirq_pkg::IMPL_MASK;
    if (wr && a == i2cirq_pkg::INT_SET_OFFS) st_m |= d & i2cirq_pkg::IMPL_MASK;
    st_m |= evb;
    n = 0;
    while (reg_ack !== 1'b1 && n < 4) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("ack", 32'h0000_0001, {31'h0, reg_ack});
    if (!wr) check("rdata", exp, reg_rdata);
    check("force", (wr && a == i2cirq_pkg::INT_SET_OFFS) ? d & i2cirq_pkg::IMPL_MASK : 0, force_ev);
    @(negedge ref_clk_in);
    check("irq", {31'h0, (st_m & en_m) != 0}, {31'h0, irq});
    if (((st_m & en_m) != 0) && !irq_m) rises_m++;
    irq_m = (st_m & en_m) != 0;
  endtask : acc

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    reg_sel = 1'b0;
    reg_wr = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    ev = '0;
    clk_en = 1'b1;
    irq_m = 1'b0;
    st_m = 0;
    en_m = 0;
    repeat (8) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    for (k = 0; k < 4; k++) acc(1'b0, addrs[k], 32'h0000_0000, 14'h0000);
    acc(1'b1, i2cirq_pkg::INT_ENABLE_OFFS, 32'hffff_ffff, 14'h0000);
    acc(1'b0, i2cirq_pkg::INT_ENABLE_OFFS, 32'h0000_0000, 14'h0000);
    // each event alone: set, read, clear by its own bit
    for (k = 0; k < 14; k++) begin
      acc(1'b0, 20'h0_0000, 32'h0000_0000, 14'h0001 << k);
      acc(1'b0, i2cirq_pkg::INT_STATUS_OFFS, 32'h0000_0000, 14'h0000);
      acc(1'b1, i2cirq_pkg::INT_STATUS_OFFS, 32'h1 << pos[k], 14'h0000);
    end
    acc(1'b1, i2cirq_pkg::INT_STATUS_OFFS, 32'hffff_ffff, 14'h3fff);
    acc(1'b0, i2cirq_pkg::INT_STATUS_OFFS, 32'h0000_0000, 14'h0000);
    acc(1'b1, i2cirq_pkg::INT_STATUS_OFFS, 32'h0000_0000, 14'h0000);
    acc(1'b1, i2cirq_pkg::INT_STATUS_OFFS, 32'hffff_ffff, 14'h0000);
    // enable low for one edge: events, a select and a set write must all be dropped
    @(negedge ref_clk_in);
    clk_en = 1'b0;
    ev = 14'h3fff;
    reg_sel = 1'b1;
    reg_wr = 1'b1;
    reg_addr = i2cirq_pkg::INT_SET_OFFS;
    reg_wdata = 32'hffff_ffff;
    @(negedge ref_clk_in);
    check("frozen ack", 32'h0000_0000, {31'h0, reg_ack});
    check("frozen force", 32'h0000_0000, force_ev);
    clk_en = 1'b1;
    reg_sel = 1'b0;
    ev = '0;
    acc(1'b0, i2cirq_pkg::INT_STATUS_OFFS, 32'h0000_0000, 14'h0000);
    acc(1'b1, i2cirq_pkg::INT_SET_OFFS, 32'hffff_ffff, 14'h0000);
    acc(1'b0, i2cirq_pkg::INT_STATUS_OFFS, 32'h0000_0000, 14'h0000);
    // random mix of accesses and events, every address among them
    for (k = 0; k < 60; k++) begin
      acc(1'($random(seed)), addrs[$unsigned($random(seed)) % 4], $random(seed), 14'($random(seed)));
    end
    // the partner counts a rise one edge after the line goes up
    @(negedge ref_clk_in);
    check("irq rises", rises_m, {16'h0000, irq_rises});
    close_out();
  end
endmodule : tb_top
